// ===== core/pes_map.svh
// Operation
// - Multiplexer repeats table section 0 within 100 ms
// - Multiplexer repeats program map within 400 ms
// - Packets up to 2^16 bytes, 16-bit length
// - Length counts bytes after length field
// - Video length is zero; never skip by it (the parser flags a nonzero video length but still ends the packet by it)
// - New video packet for every picture
// - Video payload opens with sequence/group/picture code
// - Packet starts at fresh transport payload
// - Stuffing makes packet end on transport boundary
// - Prefix 000001 then stream identifier byte
// - Classify reserved, private one, padding, private two
// - Decode audio, video, data stream numbers
// - Order: start code, flags, options, payload
// - Payload holds one elementary stream only
// - Each stream keeps its own identifier
// - Private streams pass through uninterpreted
`ifndef PES_MAP_SVH
`define PES_MAP_SVH

`define PREFIX_B0       8'h00
`define PREFIX_B1       8'h00
`define PREFIX_B2       8'h01
`define SID_RESERVED    8'hBC
`define SID_PRIVATE1    8'hBD
`define SID_PADDING     8'hBE
`define SID_PRIVATE2    8'hBF
`define SID_AUDIO_MASK  8'hE0
`define SID_AUDIO_VAL   8'hC0
`define SID_NIBBLE_MASK 8'hF0
`define SID_VIDEO_VAL   8'hE0
`define SID_DATA_VAL    8'hF0
`define SC_SEQUENCE     8'hB3
`define SC_GOP          8'hB8
`define SC_PICTURE      8'h00
`define HDR_FLAGS1      8'h80
`define HDR_FLAGS2      8'h00
`define HDR_OPT_LEN     8'h00
`define STUFF_BYTE      8'hFF
`define HDR_FIXED_BYTES 4'h6
`define HDR_FULL_BYTES  4'h9
`define FLAG_TAIL_BYTES 16'h0003
`define TP_LAST_SLOT    8'hB7
`define ALIGN_CHECK_LEN 3'h4

`define CLOCK_HZ        25000000
`define MS_CYCLES       (`CLOCK_HZ / 1000)
`define PAT_MAX_MS      100
`define PMT_MAX_MS      400
`define TABLE_GUARD_MS  10

`endif

// ===== core/pes_pkg.sv
`default_nettype none
`include "pes_map.svh"
package pes_pkg;

  typedef enum logic [2:0] {
    CLS_RESERVED = 3'h0,
    CLS_PRIVATE1 = 3'h1,
    CLS_PADDING  = 3'h2,
    CLS_PRIVATE2 = 3'h3,
    CLS_AUDIO    = 3'h4,
    CLS_VIDEO    = 3'h5,
    CLS_DATA     = 3'h6,
    CLS_OTHER    = 3'h7
  } stream_class_e;

  typedef enum logic [2:0] {
    PS_HUNT   = 3'h0,
    PS_PREFIX = 3'h1,
    PS_FLAGS  = 3'h3,
    PS_SKIP   = 3'h2,
    PS_PAY    = 3'h6,
    PS_DROP   = 3'h7
  } parse_state_e;

  typedef enum logic [1:0] {
    MS_IDLE  = 2'h0,
    MS_HDR   = 2'h1,
    MS_PAY   = 2'h3,
    MS_STUFF = 2'h2
  } mux_state_e;

  function automatic stream_class_e classify(input logic [7:0] sid);
    stream_class_e c;
    c = CLS_OTHER;
    if (sid == `SID_RESERVED) c = CLS_RESERVED;
    else if (sid == `SID_PRIVATE1) c = CLS_PRIVATE1;
    else if (sid == `SID_PADDING) c = CLS_PADDING;
    else if (sid == `SID_PRIVATE2) c = CLS_PRIVATE2;
    else if ((sid & `SID_AUDIO_MASK) == `SID_AUDIO_VAL) c = CLS_AUDIO;
    else if ((sid & `SID_NIBBLE_MASK) == `SID_VIDEO_VAL) c = CLS_VIDEO;
    else if ((sid & `SID_NIBBLE_MASK) == `SID_DATA_VAL) c = CLS_DATA;
    return c;
  endfunction : classify

  function automatic logic [4:0] stream_number(input logic [7:0] sid);
    return (classify(sid) == CLS_AUDIO) ? sid[4:0] : {1'b0, sid[3:0]};
  endfunction : stream_number

  // only audio and video carry the standard flag bytes here
  function automatic logic has_flags(input logic [7:0] sid);
    return classify(sid) == CLS_AUDIO || classify(sid) == CLS_VIDEO;
  endfunction : has_flags

  function automatic logic [7:0] prefix_byte(input logic [2:0] idx);
    logic [7:0] b;
    b = `PREFIX_B2;
    if (idx == 3'h0) b = `PREFIX_B0;
    else if (idx == 3'h1) b = `PREFIX_B1;
    return b;
  endfunction : prefix_byte

endpackage : pes_pkg
`default_nettype wire

// ===== core/pes_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pes_link_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  logic       unit_start;
  logic       tp_first;
  logic       tp_last;
  logic       stuff;

  modport mux (
    output valid,
    output data,
    output unit_start,
    output tp_first,
    output tp_last,
    output stuff,
    input  ready
  );

  modport parser (
    input  valid,
    input  data,
    input  unit_start,
    input  tp_first,
    input  tp_last,
    input  stuff,
    output ready
  );
endinterface : pes_link_if
`default_nettype wire

// ===== core/tick_divider.sv
`timescale 1ns/100ps
`default_nettype none
module tick_divider #(
  parameter int unsigned DIV = 25000
) (
  input  wire logic clock,
  input  wire logic rst,
  output logic      tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } div_s;

  div_s s_reg;
  div_s s_next;

  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.cnt == 16'(DIV - 1)) begin
      s_next.cnt = 16'h0000;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = 16'(s_reg.cnt + 16'h0001);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) s_reg <= '0;
    else s_reg <= s_next;
  end

  assign tick = s_reg.tick;
endmodule : tick_divider
`default_nettype wire

// ===== core/pes_mux_end.sv
`timescale 1ns/100ps
`default_nettype none
`include "pes_map.svh"
module pes_mux_end #(
  parameter int unsigned MS_CYCLES = `MS_CYCLES
) (
  input  wire logic   clock,
  input  wire logic   rst,
  input  wire logic [7:0]  es_data,
  input  wire logic        es_valid,
  output logic             es_ready,
  input  wire logic        es_first,
  input  wire logic        es_last,
  input  wire logic [7:0]  es_sid,
  input  wire logic [15:0] es_len,
  input  wire logic        pat_sent,
  input  wire logic        pmt_sent,
  output logic             pat_due,
  output logic             pmt_due,
  output logic             pat_late,
  output logic             pmt_late,
  pes_link_if.mux          link
);
  localparam logic [1:0][9:0] TBL_LIMIT = {10'(`PMT_MAX_MS), 10'(`PAT_MAX_MS)};
  localparam logic [9:0]      TBL_GUARD = 10'(`TABLE_GUARD_MS);

  typedef struct packed {
    pes_pkg::mux_state_e st;
    logic [3:0]          idx;
    logic [3:0]          hdr_bytes;
    logic [7:0]          sid;
    logic [15:0]         len;
    logic                any_pay;
    logic [7:0]          slot;
    logic                valid;
    logic [7:0]          data;
    logic                ustart;
    logic                first;
    logic                last;
    logic                stuff;
    logic [1:0][9:0]     tbl_ms;
    logic [1:0]          due;
    logic [1:0]          late;
  } mux_s;

  mux_s s_reg;
  mux_s s_next;
  logic ms_tick;
  logic can_load;
  logic [1:0] sent;

  function automatic logic [7:0] hdr_byte(input logic [3:0] idx, input logic [7:0] sid, input logic [15:0] len);
    logic [7:0] b;
    unique case (idx)
      4'h0, 4'h1, 4'h2: b = pes_pkg::prefix_byte(idx[2:0]);
      4'h3: b = sid;
      4'h4: b = len[15:8];
      4'h5: b = len[7:0];
      4'h6: b = `HDR_FLAGS1;
      4'h7: b = `HDR_FLAGS2;
      default: b = `HDR_OPT_LEN;
    endcase
    return b;
  endfunction : hdr_byte

  // one byte into the transport slot stream; slot 0 opens a transport payload
  function automatic mux_s put(input mux_s x, input logic [7:0] b, input logic us, input logic stf);
    mux_s y;
    y = x;
    y.valid = 1'b1;
    y.data = b;
    y.ustart = us;
    y.stuff = stf;
    y.first = (x.slot == 8'h00);
    y.last = (x.slot == `TP_LAST_SLOT);
    y.slot = y.last ? 8'h00 : 8'(x.slot + 8'h01);
    return y;
  endfunction : put

  tick_divider #(.DIV(MS_CYCLES)) u_ms (
    .clock (clock),
    .rst   (rst),
    .tick  (ms_tick)
  );

  assign sent = {pmt_sent, pat_sent};
  assign can_load = !s_reg.valid || link.ready;

  always_comb begin
    s_next = s_reg;
    if (s_reg.valid && link.ready) s_next.valid = 1'b0;
    if (can_load) begin
      unique case (s_reg.st)
        pes_pkg::MS_IDLE: begin
          if (es_valid && es_first) begin
            s_next.sid = es_sid;
            s_next.idx = 4'h0;
            s_next.any_pay = 1'b0;
            s_next.hdr_bytes = pes_pkg::has_flags(es_sid) ? `HDR_FULL_BYTES : `HDR_FIXED_BYTES;
            if (pes_pkg::classify(es_sid) == pes_pkg::CLS_VIDEO) s_next.len = 16'h0000;
            else if (pes_pkg::has_flags(es_sid)) s_next.len = 16'(es_len + `FLAG_TAIL_BYTES);
            else s_next.len = es_len;
            s_next.st = pes_pkg::MS_HDR;
          end
        end
        pes_pkg::MS_HDR: begin
          // slot is 0 at the first header byte since the previous packet was stuffed out
          s_next = put(s_next, hdr_byte(s_reg.idx, s_reg.sid, s_reg.len), s_reg.idx == 4'h0, 1'b0);
          s_next.idx = 4'(s_reg.idx + 4'h1);
          if (s_reg.idx == 4'(s_reg.hdr_bytes - 4'h1)) s_next.st = pes_pkg::MS_PAY;
        end
        pes_pkg::MS_PAY: begin
          if (es_valid) begin
            if (es_first && s_reg.any_pay) begin
              s_next.st = pes_pkg::MS_STUFF;
            end else begin
              s_next = put(s_next, es_data, 1'b0, 1'b0);
              s_next.any_pay = 1'b1;
              if (es_last) s_next.st = pes_pkg::MS_STUFF;
            end
          end
        end
        pes_pkg::MS_STUFF: begin
          if (s_reg.slot == 8'h00) s_next.st = pes_pkg::MS_IDLE;
          else s_next = put(s_next, `STUFF_BYTE, 1'b0, 1'b1);
        end
      endcase
    end
    for (int i = 0; i < 2; i++) begin
      if (sent[i]) s_next.tbl_ms[i] = 10'h000;
      else if (ms_tick && s_reg.tbl_ms[i] != TBL_LIMIT[i]) s_next.tbl_ms[i] = 10'(s_reg.tbl_ms[i] + 10'h001);
      s_next.due[i] = s_next.tbl_ms[i] >= 10'(TBL_LIMIT[i] - TBL_GUARD);
      s_next.late[i] = s_next.tbl_ms[i] >= TBL_LIMIT[i];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) s_reg <= '0;
    else s_reg <= s_next;
  end

  // the first byte of the next picture waits until the current packet is closed
  assign es_ready = can_load && s_reg.st == pes_pkg::MS_PAY && !(es_first && s_reg.any_pay);
  assign link.valid = s_reg.valid;
  assign link.data = s_reg.data;
  assign link.unit_start = s_reg.ustart;
  assign link.tp_first = s_reg.first;
  assign link.tp_last = s_reg.last;
  assign link.stuff = s_reg.stuff;
  assign pat_due = s_reg.due[0];
  assign pmt_due = s_reg.due[1];
  assign pat_late = s_reg.late[0];
  assign pmt_late = s_reg.late[1];
endmodule : pes_mux_end
`default_nettype wire

// ===== core/pes_parser_end.sv
`timescale 1ns/100ps
`default_nettype none
`include "pes_map.svh"
module pes_parser_end (
  input  wire logic                clock,
  input  wire logic                rst,
  pes_link_if.parser               link,
  output logic [7:0]               es_data,
  output logic                     es_valid,
  input  wire logic                es_ready,
  output logic                     es_first,
  output logic                     pkt_start,
  output logic                     pkt_end,
  output logic                     pkt_bounded,
  output logic [7:0]               stream_id,
  output pes_pkg::stream_class_e   stream_class,
  output logic [4:0]               stream_num,
  output logic                     err_sync,
  output logic                     err_align,
  output logic                     err_len
);
  typedef struct packed {
    pes_pkg::parse_state_e  st;
    logic [2:0]             idx;
    logic [7:0]             sid;
    pes_pkg::stream_class_e cls;
    logic [4:0]             num;
    logic [15:0]            rem;
    logic                   bounded;
    logic [7:0]             skip;
    logic [2:0]             pay_idx;
    logic                   in_pkt;
    logic                   out_valid;
    logic [7:0]             out_data;
    logic                   out_first;
    logic                   start_p;
    logic                   end_p;
    logic                   err_sync;
    logic                   err_align;
    logic                   err_len;
  } parse_s;

  parse_s s_reg;
  parse_s s_next;
  logic   take;
  logic   counted;
  logic [7:0] b;
  logic [2:0] cur;

  // payload must open with a prefix and then one of three picture-level codes
  function automatic logic align_ok(input logic [2:0] idx, input logic [7:0] v);
    logic ok;
    if (idx < 3'h3) ok = (v == pes_pkg::prefix_byte(idx));
    else ok = (v == `SC_SEQUENCE) || (v == `SC_GOP) || (v == `SC_PICTURE);
    return ok;
  endfunction : align_ok

  assign link.ready = !s_reg.out_valid || es_ready;
  assign take = link.valid && link.ready;
  assign b = link.data;
  // bytes after the length field of a bounded packet already opened
  assign counted = s_reg.in_pkt && s_reg.bounded && !link.unit_start;

  always_comb begin
    s_next = s_reg;
    cur = 3'h0;
    s_next.start_p = 1'b0;
    s_next.end_p = 1'b0;
    s_next.err_sync = 1'b0;
    s_next.err_align = 1'b0;
    s_next.err_len = 1'b0;
    if (es_ready) begin
      s_next.out_valid = 1'b0;
      s_next.out_first = 1'b0;
    end
    // stuffing slots carry nothing and never count against the length
    if (take && !link.stuff) begin
      if (link.unit_start) begin
        if (s_reg.in_pkt && !s_reg.bounded) s_next.end_p = 1'b1;
        if (s_reg.in_pkt && s_reg.bounded) s_next.err_len = 1'b1;
        s_next.in_pkt = 1'b0;
        s_next.st = pes_pkg::PS_PREFIX;
        s_next.idx = 3'h0;
      end
      unique case (s_next.st)
        pes_pkg::PS_HUNT: begin
          s_next.st = pes_pkg::PS_HUNT;
        end
        pes_pkg::PS_PREFIX: begin
          cur = s_next.idx;
          s_next.idx = 3'(cur + 3'h1);
          if (cur < 3'h3) begin
            if (b != pes_pkg::prefix_byte(cur)) begin
              s_next.err_sync = 1'b1;
              s_next.st = pes_pkg::PS_HUNT;
            end
          end else if (cur == 3'h3) begin
            s_next.sid = b;
            s_next.cls = pes_pkg::classify(b);
            s_next.num = pes_pkg::stream_number(b);
          end else if (cur == 3'h4) begin
            s_next.rem[15:8] = b;
          end else begin
            s_next.rem[7:0] = b;
            s_next.bounded = {s_reg.rem[15:8], b} != 16'h0000;
            s_next.in_pkt = 1'b1;
            s_next.start_p = 1'b1;
            s_next.pay_idx = 3'h0;
            s_next.idx = 3'h0;
            // a video length other than zero is flagged but still honoured
            if (s_next.cls == pes_pkg::CLS_VIDEO && s_next.bounded) s_next.err_len = 1'b1;
            if (s_next.cls == pes_pkg::CLS_PADDING) s_next.st = pes_pkg::PS_DROP;
            else if (pes_pkg::has_flags(s_next.sid)) s_next.st = pes_pkg::PS_FLAGS;
            else s_next.st = pes_pkg::PS_PAY;
          end
        end
        pes_pkg::PS_FLAGS: begin
          cur = s_next.idx;
          s_next.idx = 3'(cur + 3'h1);
          if (cur == 3'h2) begin
            s_next.skip = b;
            s_next.st = (b == 8'h00) ? pes_pkg::PS_PAY : pes_pkg::PS_SKIP;
          end
        end
        pes_pkg::PS_SKIP: begin
          s_next.skip = 8'(s_reg.skip - 8'h01);
          if (s_reg.skip == 8'h01) s_next.st = pes_pkg::PS_PAY;
        end
        pes_pkg::PS_PAY: begin
          s_next.out_valid = 1'b1;
          s_next.out_data = b;
          s_next.out_first = (s_reg.pay_idx == 3'h0);
          if (s_reg.pay_idx < `ALIGN_CHECK_LEN) begin
            s_next.pay_idx = 3'(s_reg.pay_idx + 3'h1);
            if (s_reg.cls == pes_pkg::CLS_VIDEO && !align_ok(s_reg.pay_idx, b)) begin
              s_next.err_align = 1'b1;
              s_next.pay_idx = `ALIGN_CHECK_LEN;
            end
          end
        end
        pes_pkg::PS_DROP: begin
          s_next.st = pes_pkg::PS_DROP;
        end
        default: begin
          s_next.st = pes_pkg::PS_HUNT;
        end
      endcase
      if (counted) begin
        s_next.rem = 16'(s_reg.rem - 16'h0001);
        if (s_reg.rem == 16'h0001) begin
          s_next.end_p = 1'b1;
          s_next.in_pkt = 1'b0;
          s_next.st = pes_pkg::PS_HUNT;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) s_reg <= '0;
    else s_reg <= s_next;
  end

  assign es_data = s_reg.out_data;
  assign es_valid = s_reg.out_valid;
  assign es_first = s_reg.out_first;
  assign pkt_start = s_reg.start_p;
  assign pkt_end = s_reg.end_p;
  assign pkt_bounded = s_reg.bounded;
  assign stream_id = s_reg.sid;
  assign stream_class = s_reg.cls;
  assign stream_num = s_reg.num;
  assign err_sync = s_reg.err_sync;
  assign err_align = s_reg.err_align;
  assign err_len = s_reg.err_len;
endmodule : pes_parser_end
`default_nettype wire

// ===== tb/pes_link_checker.sv
`timescale 1ns/100ps
`default_nettype none
module pes_link_checker (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       valid,
  input wire logic       ready,
  input wire logic [7:0] data,
  input wire logic       unit_start,
  input wire logic       tp_first,
  input wire logic       tp_last,
  input wire logic       stuff
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic       take;
  logic [7:0] slot_reg;
  assign take = valid && ready;

  // slot of the next byte inside the current transport payload
  always_ff @(posedge clock or posedge rst) begin
    if (rst) slot_reg <= 8'h00;
    else if (take) slot_reg <= tp_first ? 8'h01 : slot_reg + 8'h01;
  end

  start_prefix_a: assert property ((take && unit_start) |->
    (data == 8'h00) ##1 (valid && data == 8'h00) ##1 (valid && data == 8'h01)) else $error("start prefix wrong");
  fresh_start_a: assert property ((valid && unit_start) |-> tp_first && !stuff)
    else $error("packet start not at slot zero");
  stuff_value_a: assert property ((valid && stuff) |-> data == 8'hFF && !unit_start)
    else $error("stuffing byte wrong");
  stuff_run_a: assert property ((take && stuff && !tp_last) |=> !(valid && !stuff))
    else $error("data after stuffing before slot end");
  slot_last_a: assert property ((valid && tp_last) |-> slot_reg == 8'hB7)
    else $error("last slot flag misplaced");
  slot_first_a: assert property ((valid && tp_first) |-> slot_reg == 8'h00 || slot_reg == 8'hB8)
    else $error("first slot flag misplaced");
  video_len_a: assert property ((take && unit_start) ##3 (take && data[7:4] == 4'hE) |=>
    (data == 8'h00) ##1 (data == 8'h00)) else $error("video length not zero");
  av_flags_a: assert property ((take && unit_start) ##3 (take && (data[7:5] == 3'b110 || data[7:4] == 4'hE)) |->
    ##3 (data == 8'h80) ##1 (data == 8'h00) ##1 (data == 8'h00)) else $error("header flags misplaced");

  cover property ((take && unit_start) ##3 (data[7:4] == 4'hE));
  cover property ((take && unit_start) ##3 (data[7:5] == 3'b110));
  cover property (take && tp_first && !unit_start);
  cover property (take && stuff && tp_last);
endmodule : pes_link_checker
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int MS = 10;
  logic        clock, es_ready, pat_due, pmt_due, pat_late, pmt_late;
  logic        rst = 1'b1, es_valid = 1'b0, es_first = 1'b0, es_last = 1'b0, pat_sent = 1'b0, pmt_sent = 1'b0;
  logic [7:0]  es_data = 8'h00, es_sid = 8'h00;
  logic [15:0] es_len = 16'h0000;
  logic        p_valid, p_first, p_start, p_end, p_bnd, e_sync, e_align, e_len, f_end, f_sync, f_len, f_align;
  logic [7:0]  p_data, p_sid, exp_sid;
  logic [4:0]  p_num, exp_num;
  logic        exp_bnd;
  logic [8:0]  exp_q[$];
  pes_pkg::stream_class_e p_cls, exp_cls;
  int          n_errors, check_count, n_start, n_end, n_align, n_bad, f_end_n, f_sync_n, f_len_n, cyc, e0;
  int          f_align_n;
  logic [7:0]  sids[11] = '{8'hE3, 8'hE3, 8'hD7, 8'hBC, 8'hBD, 8'hBE, 8'hBF, 8'hF2, 8'h80, 8'hEF, 8'hC1};
  int          lens[11] = '{6, 6, 2, 3, 3, 3, 3, 3, 3, 5, 65532};

  pes_link_if link();
  pes_link_if lf();
  pes_mux_end #(.MS_CYCLES(MS)) pes_mux_end_inst (.clock(clock), .rst(rst), .es_data(es_data),
    .es_valid(es_valid), .es_ready(es_ready), .es_first(es_first), .es_last(es_last), .es_sid(es_sid),
    .es_len(es_len), .pat_sent(pat_sent), .pmt_sent(pmt_sent), .pat_due(pat_due), .pmt_due(pmt_due),
    .pat_late(pat_late), .pmt_late(pmt_late), .link(link.mux));
  pes_parser_end pes_parser_end_inst (.clock(clock), .rst(rst), .link(link.parser), .es_data(p_data),
    .es_valid(p_valid), .es_ready(1'b1), .es_first(p_first), .pkt_start(p_start), .pkt_end(p_end),
    .pkt_bounded(p_bnd), .stream_id(p_sid), .stream_class(p_cls), .stream_num(p_num), .err_sync(e_sync),
    .err_align(e_align), .err_len(e_len));
  // second parser fed by hand-made faulty traffic
  pes_parser_end pes_parser_end_inst2 (.clock(clock), .rst(rst), .link(lf.parser), .es_data(),
    .es_valid(), .es_ready(1'b1), .es_first(), .pkt_start(), .pkt_end(f_end), .pkt_bounded(),
    .stream_id(), .stream_class(), .stream_num(), .err_sync(f_sync), .err_align(f_align), .err_len(f_len));
  pes_link_checker pes_link_checker_inst (.clock(clock), .rst(rst), .valid(link.valid), .ready(link.ready),
    .data(link.data), .unit_start(link.unit_start), .tp_first(link.tp_first), .tp_last(link.tp_last),
    .stuff(link.stuff));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock) cyc <= rst ? 0 : cyc + 1;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    if (n_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  function automatic pes_pkg::stream_class_e cls_of(input logic [7:0] sid);
    casez (sid)
      8'hBC: return pes_pkg::CLS_RESERVED;
      8'hBD: return pes_pkg::CLS_PRIVATE1;
      8'hBE: return pes_pkg::CLS_PADDING;
      8'hBF: return pes_pkg::CLS_PRIVATE2;
      8'b110?????: return pes_pkg::CLS_AUDIO;
      8'b1110????: return pes_pkg::CLS_VIDEO;
      8'b1111????: return pes_pkg::CLS_DATA;
      default: return pes_pkg::CLS_OTHER;
    endcase
  endfunction : cls_of

  always @(posedge clock) begin
    if (!rst) begin
      if (p_valid) check("payload", {p_first, p_data}, exp_q.pop_front());
      if (p_start) begin
        check("class", p_cls, exp_cls);
        check("number", p_num, exp_num);
        check("bounded", p_bnd, exp_bnd);
        check("stream id", p_sid, exp_sid);
      end
      n_start += p_start;
      n_end += p_end;
      n_align += e_align;
      n_bad += e_sync + e_len;
      f_end_n += f_end;
      f_sync_n += f_sync;
      f_len_n += f_len;
      f_align_n += f_align;
    end
  end

  // waits for the encoder-side handshake; a stuck mux counts as a mismatch
  task automatic wait_take();
    int k;
    k = 0;
    @(posedge clock);
    while (!es_ready && k < 400) begin
      @(posedge clock);
      k++;
    end
    if (!es_ready) n_errors++;
    #1;
  endtask : wait_take

  task automatic send_pkt(input logic [7:0] sid, input int n);
    logic [31:0] head;
    logic [7:0]  b;
    head = (sid == 8'hEF) ? 32'h11223344 : 32'h000001B3;
    exp_sid = sid;
    exp_cls = cls_of(sid);
    exp_num = (sid[7:5] == 3'b110) ? sid[4:0] : {1'b0, sid[3:0]};
    exp_bnd = sid[7:4] != 4'hE;
    for (int i = 0; i < n; i++) begin
      b = (i < 4) ? head[31 - 8 * i -: 8] : i[7:0];
      if (sid != 8'hBE) exp_q.push_back({i == 0, b});
      es_data = b;
      es_valid = 1'b1;
      es_first = i == 0;
      // video packets are closed by the next picture start, not by a last flag
      es_last = i == n - 1 && sid[7:4] != 4'hE;
      es_sid = sid;
      es_len = n[15:0];
      wait_take();
    end
  endtask : send_pkt

  task automatic put_n(input logic [127:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      lf.valid = 1'b1;
      lf.data = v[8 * (n - 1 - i) +: 8];
      lf.unit_start = i == 0;
      lf.tp_first = i == 0;
      do @(posedge clock); while (!lf.ready);
      #1;
    end
    lf.valid = 1'b0;
    // one idle edge so the next call never re-raises valid in this time step
    @(posedge clock);
    #1;
  endtask : put_n

  task automatic at_ms(input int ms);
    while (cyc < ms * MS) @(posedge clock);
    #1;
  endtask : at_ms

  task automatic table_test(input logic pmt, input int lim);
    at_ms(lim - 15);
    check("table early", pmt ? {pmt_due, pmt_late} : {pat_due, pat_late}, 2'b00);
    at_ms(lim - 5);
    check("table due", pmt ? {pmt_due, pmt_late} : {pat_due, pat_late}, 2'b10);
    at_ms(lim + 5);
    check("table late", pmt ? {pmt_due, pmt_late} : {pat_due, pat_late}, 2'b11);
    pat_sent = !pmt;
    pmt_sent = pmt;
    @(posedge clock);
    #1;
    pat_sent = 1'b0;
    pmt_sent = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check("table sent", pmt ? {pmt_due, pmt_late} : {pat_due, pat_late}, 2'b00);
  endtask : table_test

  initial begin
    repeat (90000) @(posedge clock);
    n_errors++;
    wrap_up();
  end

  initial begin
    lf.valid = 1'b0;
    lf.data = 8'h00;
    lf.unit_start = 1'b0;
    lf.tp_first = 1'b0;
    lf.tp_last = 1'b0;
    lf.stuff = 1'b0;
    repeat (5) @(posedge clock);
    #1;
    rst = 1'b0;
    put_n(128'h000002, 3);
    repeat (3) @(posedge clock);
    check("sync", f_sync_n, 1);
    put_n(128'h000001BC0005AAAA, 8);
    put_n(128'h000001E00000800001FF000001B3, 14);
    repeat (4) @(posedge clock);
    check("cut", f_len_n, 1);
    check("skip", f_align_n, 0);
    e0 = f_end_n;
    put_n(128'h000001BD0001AA, 7);
    put_n(128'h000001E0000480000001, 10);
    repeat (4) @(posedge clock);
    check("ends", f_end_n - e0, 3);
    check("video len", f_len_n, 2);
    check("align bad", f_align_n, 1);
    table_test(1'b0, 100);
    table_test(1'b1, 400);
    foreach (sids[k]) send_pkt(sids[k], lens[k]);
    es_valid = 1'b0;
    es_last = 1'b0;
    repeat (300) @(posedge clock);
    check("starts", n_start, 11);
    check("ends", n_end, 11);
    check("align", n_align, 1);
    check("errors", n_bad, 0);
    check("left", exp_q.size(), 0);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
